// ==== include/ardp_cfg.svh ====
// Constants for the AES round state datapath.
`ifndef ARDP_CFG_SVH
`define ARDP_CFG_SVH
`define ARDP_BLOCK_W 128
`define ARDP_WORD_W 32
`define ARDP_LATENCY 1
`define ARDP_ROUNDS_128 4'ha
`define ARDP_ROUNDS_192 4'hc
`define ARDP_ROUNDS_256 4'he
`define ARDP_POLY_LOW 8'h1b
`define ARDP_RST_ROUNDS 4'h0
`endif

// ==== include/ardp_pkg.sv ====
// Types shared by the AES round state datapath and its users.
package ardp_pkg;

    typedef enum logic [2:0] {
        ARDP_ENCRYPT_ROUND_OP = 3'b000,
        ARDP_ENCRYPT_FINAL_ROUND_OP = 3'b001,
        ARDP_DECRYPT_ROUND_OP = 3'b010,
        ARDP_DECRYPT_FINAL_ROUND_OP = 3'b011,
        ARDP_INVERSE_COLUMN_MIX_OP = 3'b100,
        ARDP_ROUND_KEY_ASSIST_OP = 3'b101
    } ardp_op_t;

    typedef enum logic [1:0] {
        ARDP_KEY_128 = 2'b00,
        ARDP_KEY_192 = 2'b01,
        ARDP_KEY_256 = 2'b10
    } ardp_key_len_t;

    typedef struct packed {
        logic valid;
        ardp_op_t op;
        ardp_key_len_t key_len;
        logic [7:0] imm;
        logic [127:0] state;
        logic [127:0] key;
    } ardp_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] rounds;
        logic [127:0] result;
    } ardp_rsp_t;

endpackage : ardp_pkg

// ==== src/ardp_datapath.sv ====
// AES round state datapath: one operation accepted per cycle, result one cycle later.
// What this block does
// - Each round operation takes a 128-bit state and a 128-bit round key, the key coming from register or memory.
// - Key lengths of 128, 192 and 256 bits are supported with 10, 12 and 14 rounds.
// - The state is four 32-bit words, word 0 in bits 31 to 0 and word 3 in bits 127 to 96.
// - Matrix element at row i, column j is byte 4*j+i, so each column is one word with row 0 lowest.
// - There is a middle encryption round and a final encryption round operation.
// - There is a middle and a final decryption round in the equivalent inverse cipher order.
// - A standalone operation applies only the inverse column mixing to its operand.
// - A key assist operation helps derive round keys from the cipher key.
// - Row shifting keeps row 0 and rotates rows 1, 2 and 3 left by one, two and three bytes.
// - Column mixing weights the column bytes by the circulant coefficients 02, 03, 01, 01.
// - Field multiplication is carry-less and reduced by x^8+x^4+x^3+x+1; addition is xor.
// - Byte substitution looks each byte up in a 16x16 table, upper nibble row, lower column.
`timescale 1ns/1ps
`include "ardp_cfg.svh"

module ardp_datapath (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire ardp_pkg::ardp_req_t req_i,
    output ardp_pkg::ardp_rsp_t rsp_o
);

    // ****************************************************************
    // Substitution tables, entry 0 in the top byte.
    // ****************************************************************
    localparam logic [2047:0] FWD_TABLE = {
        128'h637c777bf26b6fc53001672bfed7ab76, 128'hca82c97dfa5947f0add4a2af9ca472c0,
        128'hb7fd9326363ff7cc34a5e5f171d83115, 128'h04c723c31896059a071280e2eb27b275,
        128'h09832c1a1b6e5aa0523bd6b329e32f84, 128'h53d100ed20fcb15b6acbbe394a4c58cf,
        128'hd0efaafb434d338545f9027f503c9fa8, 128'h51a3408f929d38f5bcb6da2110fff3d2,
        128'hcd0c13ec5f974417c4a77e3d645d1973, 128'h60814fdc222a908846eeb814de5e0bdb,
        128'he0323a0a4906245cc2d3ac629195e479, 128'he7c8376d8dd54ea96c56f4ea657aae08,
        128'hba78252e1ca6b4c6e8dd741f4bbd8b8a, 128'h703eb5664803f60e613557b986c11d9e,
        128'he1f8981169d98e949b1e87e9ce5528df, 128'h8ca1890dbfe6426841992d0fb054bb16
    };
    localparam logic [2047:0] INV_TABLE = {
        128'h52096ad53036a538bf40a39e81f3d7fb, 128'h7ce339829b2fff87348e4344c4dee9cb,
        128'h547b9432a6c2233dee4c950b42fac34e, 128'h082ea16628d924b2765ba2496d8bd125,
        128'h72f8f66486689816d4a45ccc5d65b692, 128'h6c704850fdedb9da5e154657a78d9d84,
        128'h90d8ab008cbcd30af7e45805b8b34506, 128'hd02c1e8fca3f0f02c1afbd0301138a6b,
        128'h3a9111414f67dcea97f2cfcef0b4e673, 128'h96ac7422e7ad3585e2f937e81c75df6e,
        128'h47f11a711d29c5896fb7620eaa18be1b, 128'hfc563e4bc6d279209adbc0fe78cd5af4,
        128'h1fdda8338807c731b11210592780ec5f, 128'h60517fa919b54a0d2de57a9f93c99cef,
        128'ha0e03b4dae2af5b0c8ebbb3c83539961, 128'h172b047eba77d626e169146355210c7d
    };

    // ****************************************************************
    // Field arithmetic and transformations.
    // ****************************************************************
    function automatic logic [7:0] ff_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] acc;
        logic [7:0] p;
        acc = 8'h00;
        p = a;
        for (int k = 0; k < 8; k++)
        begin
            if (b[k])
            begin
                acc = acc ^ p;
            end
            p = {p[6:0], 1'b0} ^ (p[7] ? `ARDP_POLY_LOW : 8'h00);
        end
        return acc;
    endfunction : ff_mul

    // The upper nibble picks the row of sixteen, the lower nibble the column.
    function automatic logic [7:0] sub_byte(input logic [7:0] x, input logic inv);
        logic [11:0] pos;
        pos = {1'b0, x[7:4], x[3:0], 3'b000};
        return inv ? INV_TABLE[12'h7ff - pos -: 8] : FWD_TABLE[12'h7ff - pos -: 8];
    endfunction : sub_byte

    function automatic logic [127:0] byte_substitution(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        o = '0;
        for (int b = 0; b < 16; b++)
        begin
            o[8*b +: 8] = sub_byte(s[8*b +: 8], inv);
        end
        return o;
    endfunction : byte_substitution

    // Element (r, c) sits at byte 4*c+r; word c is column c with row 0 lowest.
    function automatic logic [127:0] row_shifting(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        o = '0;
        for (int c = 0; c < 4; c++)
        begin
            for (int r = 0; r < 4; r++)
            begin
                if (inv)
                begin
                    o[8*(4*c+r) +: 8] = s[8*(4*((c+4-r)%4)+r) +: 8];
                end
                else
                begin
                    o[8*(4*c+r) +: 8] = s[8*(4*((c+r)%4)+r) +: 8];
                end
            end
        end
        return o;
    endfunction : row_shifting

    // The coefficient row is circulant: output row r uses coef[(k-r)%4] on input row k.
    function automatic logic [127:0] column_mixing(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        logic [31:0] coef;
        logic [7:0] acc;
        coef = inv ? 32'h090d0b0e : 32'h01010302;
        o = '0;
        for (int c = 0; c < 4; c++)
        begin
            for (int r = 0; r < 4; r++)
            begin
                acc = 8'h00;
                for (int k = 0; k < 4; k++)
                begin
                    acc = acc ^ ff_mul(coef[8*((k+4-r)%4) +: 8], s[8*(4*c+k) +: 8]);
                end
                o[8*(4*c+r) +: 8] = acc;
            end
        end
        return o;
    endfunction : column_mixing

    function automatic logic [31:0] sub_word(input logic [31:0] w);
        return {sub_byte(w[31:24], 1'b0), sub_byte(w[23:16], 1'b0),
                sub_byte(w[15:8], 1'b0), sub_byte(w[7:0], 1'b0)};
    endfunction : sub_word

    // An unused key length code answers with zero rounds rather than a guess.
    function automatic logic [3:0] rounds_for(input ardp_pkg::ardp_key_len_t kl);
        logic [3:0] n;
        case (kl)
            ardp_pkg::ARDP_KEY_128: n = `ARDP_ROUNDS_128;
            ardp_pkg::ARDP_KEY_192: n = `ARDP_ROUNDS_192;
            ardp_pkg::ARDP_KEY_256: n = `ARDP_ROUNDS_256;
            default: n = `ARDP_RST_ROUNDS;
        endcase
        return n;
    endfunction : rounds_for

    // ****************************************************************
    // State: the registered response.
    // ****************************************************************
    ardp_pkg::ardp_rsp_t st_q;
    ardp_pkg::ardp_rsp_t st_d;

    // ****************************************************************
    // Operand paths.
    // ****************************************************************
    // Both round cores are built every cycle; the operation code only picks one.
    logic [127:0] fwd_core;
    logic [127:0] inv_core;
    logic [31:0] sw1;
    logic [31:0] sw3;
    logic [31:0] rcon;

    // ****************************************************************
    // Next response.
    // ****************************************************************
    always_comb
    begin
        fwd_core = byte_substitution(row_shifting(req_i.state, 1'b0), 1'b0);
        inv_core = byte_substitution(row_shifting(req_i.state, 1'b1), 1'b1);
        sw1 = sub_word(req_i.state[63:32]);
        sw3 = sub_word(req_i.state[127:96]);
        rcon = {24'h000000, req_i.imm};
        st_d = st_q;
        st_d.valid = req_i.valid;
        // Result and rounds hold while no request is taken.
        if (req_i.valid)
        begin
            st_d.rounds = rounds_for(req_i.key_len);
            case (req_i.op)
                ardp_pkg::ARDP_ENCRYPT_ROUND_OP:
                    st_d.result = column_mixing(fwd_core, 1'b0) ^ req_i.key;
                ardp_pkg::ARDP_ENCRYPT_FINAL_ROUND_OP:
                    st_d.result = fwd_core ^ req_i.key;
                ardp_pkg::ARDP_DECRYPT_ROUND_OP:
                    st_d.result = column_mixing(inv_core, 1'b1) ^ req_i.key;
                ardp_pkg::ARDP_DECRYPT_FINAL_ROUND_OP:
                    st_d.result = inv_core ^ req_i.key;
                ardp_pkg::ARDP_INVERSE_COLUMN_MIX_OP:
                    st_d.result = column_mixing(req_i.state, 1'b1);
                ardp_pkg::ARDP_ROUND_KEY_ASSIST_OP:
                    // Rotation is right by one byte in little-endian order.
                    st_d.result = {{sw3[7:0], sw3[31:8]} ^ rcon, sw3,
                                   {sw1[7:0], sw1[31:8]} ^ rcon, sw1};
                default:
                    st_d.result = '0;
            endcase
        end
    end

    // ****************************************************************
    // Response register.
    // ****************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            // Reset clears the answer so no stale result is seen as valid.
            st_q <= '{valid: 1'b0, rounds: `ARDP_RST_ROUNDS, result: '0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign rsp_o = st_q;

endmodule : ardp_datapath

// ==== tb/ardp_datapath_assertions.sv ====
// Port checks for the AES round state datapath.
`timescale 1ns/1ps
module ardp_datapath_chk (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire ardp_pkg::ardp_req_t req_i,
    input wire ardp_pkg::ardp_rsp_t rsp_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_take;
        req_i.valid;
    endsequence
    sequence s_idle;
        !req_i.valid;
    endsequence
    latency_one_a: assert property (
        s_take |=> rsp_o.valid) else $error("no answer one cycle after request");
    no_spurious_a: assert property (
        s_idle |=> !rsp_o.valid) else $error("answer without request");
    rounds_short_a: assert property (
        s_take ##0 (req_i.key_len == 2'b00) |=> rsp_o.rounds == 4'ha) else $error("rounds not 10");
    rounds_mid_a: assert property (
        s_take ##0 (req_i.key_len == 2'b01) |=> rsp_o.rounds == 4'hc) else $error("rounds not 12");
    rounds_long_a: assert property (
        s_take ##0 (req_i.key_len == 2'b10) |=> rsp_o.rounds == 4'he) else $error("rounds not 14");
    result_hold_a: assert property (
        s_idle |=> $stable(rsp_o.result) && $stable(rsp_o.rounds)) else $error("output moved idle");
    enc_zero_a: assert property (
        s_take ##0 (req_i.op[2:1] == 2'b00 && req_i.state == '0 && req_i.key == '0)
        |=> rsp_o.result == {16{8'h63}}) else $error("zero encrypt wrong");
    dec_zero_a: assert property (
        s_take ##0 (req_i.op[2:1] == 2'b01 && req_i.state == '0 && req_i.key == '0)
        |=> rsp_o.result == {16{8'h52}}) else $error("zero decrypt wrong");
    imc_zero_a: assert property (
        s_take ##0 (req_i.op == ardp_pkg::ARDP_INVERSE_COLUMN_MIX_OP && req_i.state == '0)
        |=> rsp_o.result == '0) else $error("zero column mix wrong");
endmodule : ardp_datapath_chk
bind ardp_datapath ardp_datapath_chk u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .req_i(req_i), .rsp_o(rsp_o));

// ==== tb/ardp_issue_model.sv ====
// Issue-side model that hands operand pairs to the datapath.
`timescale 1ns/1ps
module ardp_issue_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire ardp_pkg::ardp_req_t cmd_i,
    output ardp_pkg::ardp_req_t req_o
);
    // Idle operands are inverted so a stale value is never taken for a live one.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            req_o <= '0;
        else if (cmd_i.valid)
            req_o <= cmd_i;
        else
            req_o <= {1'b0, req_o.op, req_o.key_len, ~req_o.imm, ~req_o.state, ~req_o.key};
    end
endmodule : ardp_issue_model

// ==== tb/test_aes_round_state_datapath.sv ====
// Self-checking bench for the AES round state datapath.
`timescale 1ns/1ps
module test_aes_round_state_datapath;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    ardp_pkg::ardp_req_t cmd = '0;
    ardp_pkg::ardp_req_t req;
    ardp_pkg::ardp_rsp_t rsp_o;
    ardp_pkg::ardp_rsp_t exp_q[$];
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    integer seed = 1;
    always #2 sys_clk_i = ~sys_clk_i;
    ardp_issue_model u_issue (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .req_o(req));
    ardp_datapath u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req), .rsp_o(rsp_o));
    function automatic logic [7:0] gm(logic [7:0] a, logic [7:0] b);
        logic [7:0] p = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i]) p ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
        end
        return p;
    endfunction : gm
    function automatic logic [7:0] ginv(logic [7:0] a);
        logic [7:0] r = 8'h00;
        for (int x = 1; x < 256; x++)
            if (gm(a, 8'(x)) == 8'h01) r = 8'(x);
        return r;
    endfunction : ginv
    function automatic logic [7:0] rl(logic [7:0] v, int k);
        return 8'(({v, v} << k) >> 8);
    endfunction : rl
    function automatic logic [7:0] sb(logic [7:0] a);
        logic [7:0] v;
        v = ginv(a);
        return v ^ rl(v, 1) ^ rl(v, 2) ^ rl(v, 3) ^ rl(v, 4) ^ 8'h63;
    endfunction : sb
    function automatic logic [7:0] isb(logic [7:0] a);
        return ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05);
    endfunction : isb
    function automatic logic [127:0] shs(logic [127:0] s, bit inv);
        logic [127:0] t;
        int c;
        for (int n = 0; n < 16; n++)
        begin
            c = (n / 4 + (inv ? 4 - n % 4 : n % 4)) % 4;
            t[8*n+:8] = inv ? isb(s[8*(4*c+n%4)+:8]) : sb(s[8*(4*c+n%4)+:8]);
        end
        return t;
    endfunction : shs
    function automatic logic [127:0] mix(logic [127:0] s, bit inv);
        logic [127:0] t = '0;
        logic [31:0] cf;
        cf = inv ? 32'h090d0b0e : 32'h01010302;
        for (int n = 0; n < 16; n++)
            for (int k = 0; k < 4; k++)
                t[8*n+:8] ^= gm(cf[8*((k-n%4+4)%4)+:8], s[8*(n/4*4+k)+:8]);
        return t;
    endfunction : mix
    function automatic logic [31:0] sw(logic [31:0] w);
        for (int i = 0; i < 4; i++) w[8*i+:8] = sb(w[8*i+:8]);
        return w;
    endfunction : sw
    function automatic logic [127:0] model(ardp_pkg::ardp_req_t q);
        logic [31:0] a;
        logic [31:0] b;
        a = sw(q.state[127:96]);
        b = sw(q.state[63:32]);
        case (q.op)
            3'h0: return mix(shs(q.state, 1'b0), 1'b0) ^ q.key;
            3'h1: return shs(q.state, 1'b0) ^ q.key;
            3'h2: return mix(shs(q.state, 1'b1), 1'b1) ^ q.key;
            3'h3: return shs(q.state, 1'b1) ^ q.key;
            3'h4: return mix(q.state, 1'b1);
            3'h5: return {{a[7:0], a[31:8]} ^ {24'h0, q.imm}, a,
                {b[7:0], b[31:8]} ^ {24'h0, q.imm}, b};
            default: return '0;
        endcase
    endfunction : model
    function automatic logic [127:0] r128();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction : r128
    function automatic logic [127:0] refl(logic [127:0] v);
        for (int n = 0; n < 8; n++) {v[8*n+:8], v[8*(15-n)+:8]} = {v[8*(15-n)+:8], v[8*n+:8]};
        return v;
    endfunction : refl
    task automatic chk(logic [132:0] got, logic [132:0] want);
        checked++;
        if (got !== want)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk
    task automatic send(logic [2:0] op, logic [1:0] kl, logic [127:0] s, logic [127:0] k,
        bit kat = 1'b0, logic [127:0] want = '0);
        ardp_pkg::ardp_rsp_t e;
        logic [127:0] r;
        cmd = {1'b1, op, kl, kat ? 8'h01 : 8'($random(seed)), s, k};
        r = kat ? want : model(cmd);
        e = {1'b1, kl == 2'b11 ? 4'h0 : 4'ha + {1'b0, kl, 1'b0}, r};
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        #1;
    endtask : send
    task automatic idle(int n);
        cmd.valid = 1'b0;
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : idle
    task automatic end_sim();
        if (exp_q.size() != 0) err_count++;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            end_sim();
        end
        else if (rsp_o.valid === 1'b1)
        begin
            chk(rsp_o, exp_q.size() ? exp_q.pop_front() : '0);
        end
    end
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        for (int i = 0; i < 32; i++) send(3'(i / 4), 2'(i), r128(), r128());
        idle(3);
        $display("done: all ops and key lengths back to back");
        for (int o = 0; o < 4; o++) send(3'(o), 2'(o), '0, '0);
        send(3'h4, 2'h0, '0, r128());
        send(3'h0, 2'h1, refl(128'h000102030405060708090a0b0c0d0e0f), r128());
        send(3'h0, 2'h0, refl(128'h193de3bea0f4e22b9ac68d2ae9f84808),
            refl(128'ha0fafe1788542cb123a339392a6c7605), 1'b1,
            refl(128'ha49c7ff2689f352b6b5bea43026a5049));
        send(3'h4, 2'h0, refl(128'h046681e5e0cb199a48f8d37a2806264c), r128(),
            1'b1, refl(128'hd4bf5d30e0b452aeb84111f11e2798e5));
        send(3'h3, 2'h0, refl(128'hd4bf5d30e0b452aeb84111f11e2798e5), '0,
            1'b1, refl(128'h193de3bea0f4e22b9ac68d2ae9f84808));
        send(3'h5, 2'h0, refl(128'h2b7e151628aed2a6abf7158809cf4f3c), r128(),
            1'b1, refl(128'h34e4b524e5b52434018a84eb8b84eb01));
        send(3'h5, 2'h2, {4{32'hffffffff}}, r128());
        idle(3);
        $display("done: corner operands");
        for (int i = 0; i < 200; i++)
        begin
            send(3'($unsigned($random(seed)) % 6), 2'($random(seed)), r128(), r128());
            if ($random(seed) & 1) idle(1 + ($random(seed) & 3));
        end
        idle(3);
        $display("done: random traffic with gaps");
        rst_n_i = 1'b0;
        idle(2);
        chk(rsp_o, '0);
        rst_n_i = 1'b1;
        send(3'h2, 2'h0, r128(), r128());
        idle(3);
        $display("done: reset in mid run");
        end_sim();
    end
endmodule : test_aes_round_state_datapath
